//--- include/aisel_regs.svh
// register offsets, field positions, reset values and timing counts of the input/reference selector
`ifndef AISEL_REGS_SVH
`define AISEL_REGS_SVH

// register indices as printed, byte address is four times the index
`define AISEL_IDX_SELECT 6'd7
`define AISEL_IDX_CTRL 6'd8
`define AISEL_IDX_ACTIVE 6'd9
`define AISEL_ADDR_SELECT (`AISEL_IDX_SELECT * 6'd4)
`define AISEL_ADDR_CTRL (`AISEL_IDX_CTRL * 6'd4)
`define AISEL_ADDR_ACTIVE (`AISEL_IDX_ACTIVE * 6'd4)

// selection register layout
`define AISEL_SELECT_RESET 8'h00
`define AISEL_REF_HI 7
`define AISEL_REF_LO 6
`define AISEL_CHAN_HI 5
`define AISEL_CHAN_LO 0

// control register layout
`define AISEL_CTRL_ENABLE 7
`define AISEL_CTRL_START 6
`define AISEL_CTRL_DONE 4
`define AISEL_CTRL_LONG 0

// reference codes
`define AISEL_REF_SUPPLY 2'b00
`define AISEL_REF_EXTERNAL 2'b01
`define AISEL_REF_INTERNAL 2'b10

// special channel codes and analog node numbers
`define AISEL_CHAN_TEMP 6'h22
`define AISEL_NODE_GND 4'h8
`define AISEL_NODE_BANDGAP 4'h9
`define AISEL_NODE_TEMP 4'hA

// converter clock cycles per conversion and system clocks per converter clock
`define AISEL_NORMAL_TICKS 5'd13
`define AISEL_LONG_TICKS 5'd25
`define AISEL_ADC_DIV 4'd8

`endif

//--- include/aisel_pkg.sv
// types shared by the input/reference selector
package aisel_pkg;

    // conversion state, one-hot
    typedef enum logic [1:0] {
        AISEL_IDLE = 2'b01,
        AISEL_CONV = 2'b10
    } aisel_state_t;

    // decoded analog routing of one channel code
    typedef struct packed {
        logic [3:0] pos;
        logic [3:0] neg;
        logic diff;
        logic gain20;
        logic temp;
        logic cal;
    } aisel_route_t;

endpackage

//--- logic/aisel_top.sv
// converter input multiplexer and reference selector with its register slave
`timescale 1ns/1ps
// What this block does
// - reference code 00 supply, 01 external pin, 10 internal 1.1V, 11 reserved.
// - reference writes during a conversion wait until that conversion completes.
// - channel writes during a conversion wait until that conversion completes.
// - any reference change makes the next conversion 25 converter clocks long.
// - channel field picks the connected inputs and, for differential, the gain.
// - codes 0-7 single pins, 100000 ground, 100001 bandgap, 100010 temperature.
// - the temperature channel code also switches the temperature sensor on.
// - codes 001000 to 011111 are forward differential pairs.
// - codes 101000 to 111111 are reversed differential pairs.
// - codes 100011 to 100111 short one input to both sides for calibration.
// - for differential codes the lowest bit selects 1x or 20x gain.
// - the top bit swaps positive and negative inputs of normal pairs.
// - the full differential pair table is decoded.
// - shorted pairs exist for inputs 0 (20x only), 3 and 7.
// - the selection register resets to zero and is fully read/write.
// - done flag rises at conversion end; pending selections commit then.
// - normal conversion takes 13 converter clocks, initialising one 25.
// - clearing enable during a conversion aborts it at once.
`include "aisel_regs.svh"

module aisel_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [3:0] pos_input_sel,
    output logic [3:0] neg_input_sel,
    output logic diff_mode,
    output logic gain_20x,
    output logic temp_sensor_en,
    output logic offset_cal,
    output logic ref_supply_sel,
    output logic ext_ref_connect,
    output logic internal_ref_on,
    output logic conv_sample,
    output logic conv_done_pulse
);
    import aisel_pkg::*;

    // ****************************************
    // decode functions
    // ****************************************

    // channel code to analog routing
    function automatic aisel_route_t decode_chan(input logic [5:0] c);
        aisel_route_t r;
        logic [7:0] pair;
        r = '0;
        pair = 8'h00;
        case (c[4:1]) // forward pair table, positive in high nibble
            4'h4: pair = 8'h01;
            4'h5: pair = 8'h03;
            4'h6: pair = 8'h12;
            4'h7: pair = 8'h13;
            4'h8: pair = 8'h23;
            4'h9: pair = 8'h34;
            4'hA: pair = 8'h35;
            4'hB: pair = 8'h36;
            4'hC: pair = 8'h37;
            4'hD: pair = 8'h45;
            4'hE: pair = 8'h56;
            default: pair = 8'h67;
        endcase
        if (c[5:3] == 3'b000) begin
            r.pos = {1'b0, c[2:0]};
            r.neg = `AISEL_NODE_GND;
        end else if (c[5:3] == 3'b100) begin
            case (c[2:0])
                3'd0: begin
                    r.pos = `AISEL_NODE_GND;
                    r.neg = `AISEL_NODE_GND;
                end
                3'd1: begin
                    r.pos = `AISEL_NODE_BANDGAP;
                    r.neg = `AISEL_NODE_GND;
                end
                3'd2: begin
                    r.pos = `AISEL_NODE_TEMP;
                    r.neg = `AISEL_NODE_GND;
                    r.temp = 1'b1;
                end
                3'd3: begin
                    r.cal = 1'b1;
                    r.diff = 1'b1;
                    r.gain20 = 1'b1;
                end
                3'd4, 3'd5: begin
                    r.pos = 4'h3;
                    r.neg = 4'h3;
                    r.cal = 1'b1;
                    r.diff = 1'b1;
                    r.gain20 = c[0];
                end
                default: begin
                    r.pos = 4'h7;
                    r.neg = 4'h7;
                    r.cal = 1'b1;
                    r.diff = 1'b1;
                    r.gain20 = c[0];
                end
            endcase
        end else begin
            r.diff = 1'b1;
            r.gain20 = c[0];
            r.pos = c[5] ? pair[3:0] : pair[7:4];
            r.neg = c[5] ? pair[7:4] : pair[3:0];
        end
        return r;
    endfunction

    // ****************************************
    // bus slave
    // ****************************************

    logic [7:0] select_reg;
    logic [1:0] ref_active;
    logic [5:0] chan_active;
    logic enable;
    logic done_flag;
    logic long_pending;
    logic conv_long;
    aisel_state_t state;
    logic [4:0] ticks_left;
    logic [3:0] div_count;
    aisel_route_t route;

    // a request is answered on the second edge: waitrequest drops for exactly one cycle
    wire bus_req = avs_read || avs_write;
    wire wr_fire = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire wr_select = wr_fire && (avs_address == `AISEL_ADDR_SELECT);
    wire wr_ctrl = wr_fire && (avs_address == `AISEL_ADDR_CTRL);
    wire busy = (state == AISEL_CONV);
    wire [7:0] ctrl_view = {enable, busy, 1'b0, done_flag, 3'b000, conv_long};
    wire [7:0] active_view = {ref_active, chan_active};
    wire [7:0] read_mux = (avs_address == `AISEL_ADDR_SELECT) ? select_reg :
                          (avs_address == `AISEL_ADDR_CTRL) ? ctrl_view :
                          (avs_address == `AISEL_ADDR_ACTIVE) ? active_view : 8'h00;
    wire next_waitrequest = !(bus_req && avs_waitrequest);

    // answer registers, readdata captured while waitrequest is still high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= next_waitrequest;
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= {24'h00_0000, read_mux};
            end
        end
    end

    // selection register, every bit kept as written, reserved code included
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            select_reg <= `AISEL_SELECT_RESET;
        end else if (wr_select) begin
            select_reg <= avs_writedata[7:0];
        end
    end

    // ****************************************
    // conversion timing
    // ****************************************

    // commit only while idle or on the completing edge, so a running conversion keeps its inputs
    wire tick = (div_count == `AISEL_ADC_DIV - 4'd1);
    wire conv_finish = busy && enable && tick && (ticks_left == 5'd1);
    wire commit = !busy || conv_finish;
    wire ref_change = commit && (select_reg[`AISEL_REF_HI:`AISEL_REF_LO] != ref_active);
    wire conv_start = wr_ctrl && !busy && avs_writedata[`AISEL_CTRL_START] && avs_writedata[`AISEL_CTRL_ENABLE];
    // first conversion after enabling, or any reference change, runs long
    wire start_long = long_pending || !enable || ref_change;
    wire [4:0] start_ticks = start_long ? `AISEL_LONG_TICKS : `AISEL_NORMAL_TICKS;
    wire next_done = conv_finish || (done_flag && !(wr_ctrl && avs_writedata[`AISEL_CTRL_DONE]));

    // state machine: idle until started, abort on enable low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= AISEL_IDLE;
        end else begin
            case (state)
                AISEL_IDLE: if (conv_start) state <= AISEL_CONV;
                AISEL_CONV: if (!enable || conv_finish) state <= AISEL_IDLE;
                default: state <= AISEL_IDLE;
            endcase
        end
    end

    // converter clock divider and remaining-cycle counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= 4'd0;
            ticks_left <= 5'd0;
        end else if (conv_start) begin
            div_count <= 4'd0;
            ticks_left <= start_ticks;
        end else if (busy) begin
            div_count <= tick ? 4'd0 : div_count + 4'd1;
            if (tick) ticks_left <= ticks_left - 5'd1;
        end
    end

    // control bits; completion wins over a same-cycle clear of the done flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= 1'b0;
            done_flag <= 1'b0;
            long_pending <= 1'b1;
            conv_long <= 1'b0;
        end else begin
            if (wr_ctrl) enable <= avs_writedata[`AISEL_CTRL_ENABLE];
            done_flag <= next_done;
            if (conv_start) begin
                long_pending <= 1'b0;
                conv_long <= start_long;
            end else if (ref_change || !enable) begin
                long_pending <= 1'b1;
            end
        end
    end

    // ****************************************
    // analog routing outputs
    // ****************************************

    wire aisel_route_t next_route = decode_chan(select_reg[`AISEL_CHAN_HI:`AISEL_CHAN_LO]);

    // active selection and its decoded routing move together at commit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_active <= 2'b00;
            chan_active <= 6'h00;
            route <= '{pos: 4'h0, neg: `AISEL_NODE_GND, default: 1'b0};
        end else if (commit) begin
            ref_active <= select_reg[`AISEL_REF_HI:`AISEL_REF_LO];
            chan_active <= select_reg[`AISEL_CHAN_HI:`AISEL_CHAN_LO];
            route <= next_route;
        end
    end

    // reserved code falls back to the supply so no reference node floats
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_supply_sel <= 1'b1;
            ext_ref_connect <= 1'b0;
            internal_ref_on <= 1'b0;
        end else if (commit) begin
            ref_supply_sel <= select_reg[7:6] == `AISEL_REF_SUPPLY || select_reg[7:6] == 2'b11;
            ext_ref_connect <= select_reg[7:6] == `AISEL_REF_EXTERNAL;
            internal_ref_on <= select_reg[7:6] == `AISEL_REF_INTERNAL;
        end
    end

    // conversion strobes to the sample-and-hold core
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_sample <= 1'b0;
            conv_done_pulse <= 1'b0;
        end else begin
            conv_sample <= conv_start || (busy && enable && !conv_finish);
            conv_done_pulse <= conv_finish;
        end
    end

    assign pos_input_sel = route.pos;
    assign neg_input_sel = route.neg;
    assign diff_mode = route.diff;
    assign gain_20x = route.gain20;
    assign temp_sensor_en = route.temp;
    assign offset_cal = route.cal;

    // ****************************************
    // assertions
    // ****************************************

    aisel_route_t swapped_route;
    assign swapped_route = decode_chan({~chan_active[5], chan_active[4:0]});

    sequence seq_finish;
        conv_finish;
    endsequence

    sequence seq_committed;
        ##1 (active_view == $past(select_reg)) && done_flag && conv_done_pulse;
    endsequence

    a_ref_decode_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ref_active == 2'b01) |-> (ext_ref_connect && !internal_ref_on && !ref_supply_sel))
        else $error("external reference code drives wrong outputs");

    a_reserved_ref_safe: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ref_active == 2'b11) |-> (ref_supply_sel && !ext_ref_connect && !internal_ref_on))
        else $error("reserved reference code not mapped to supply");

    a_select_frozen_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (busy && !conv_finish && enable) |=> $stable(active_view) && $stable(route))
        else $error("selection changed during conversion");

    a_commit_at_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_finish |-> seq_committed)
        else $error("pending selection not committed at completion");

    // a reference change is remembered in long_pending until the next start, so both paths count
    a_long_after_ref: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (conv_start && (long_pending || ref_change)) |=> (ticks_left == `AISEL_LONG_TICKS) && conv_long)
        else $error("reference change did not force a long conversion");

    a_normal_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (conv_start && !start_long) |=> (ticks_left == 5'd13) [*8])
        else $error("normal conversion length wrong");

    // after an abort the core is idle and no completion is reported
    sequence seq_aborted;
        ##1 !busy && !conv_sample && !conv_done_pulse && !$rose(done_flag);
    endsequence

    a_abort_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (busy && !enable) |-> seq_aborted)
        else $error("disable did not abort conversion");

    a_temp_sensor_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        temp_sensor_en == (chan_active == `AISEL_CHAN_TEMP))
        else $error("temperature sensor enable mismatch");

    a_gain_from_lsb: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (diff_mode && chan_active != 6'h23) |-> (gain_20x == chan_active[0]))
        else $error("differential gain not taken from lowest bit");

    a_polarity_swap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (chan_active[4:3] != 2'b00) |-> (swapped_route.pos == neg_input_sel) && (swapped_route.neg == pos_input_sel))
        else $error("polarity bit does not swap inputs");

endmodule

//--- verification/aisel_analog_model.sv
// behavioural sample-and-hold core that times conversions and watches the routing
`timescale 1ns/1ps
module aisel_analog_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [16:0] routing,
    input wire logic conv_sample,
    input wire logic conv_done_pulse,
    output int last_len,
    output int done_count,
    output int hold_err
);
    int run;
    logic [16:0] held;

    // conversion length, completions, and a steady route while the hold capacitor samples
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 0;
            last_len <= 0;
            done_count <= 0;
            hold_err <= 0;
            held <= 17'h0_0000;
        end else begin
            if (conv_sample) begin
                run <= run + 1;
            end else if (run != 0) begin
                last_len <= run;
                run <= 0;
            end
            if (conv_done_pulse) begin
                done_count <= done_count + 1;
            end
            // a route change mid-conversion would smear the sampled charge
            if (conv_sample && run == 0) begin
                held <= routing;
            end else if (conv_sample && held !== routing) begin
                hold_err <= hold_err + 1;
            end
        end
    end
endmodule

//--- verification/adc_input_reference_select_test.sv
// self-checking bench for the input/reference selector
`timescale 1ns/1ps
`include "aisel_regs.svh"
module adc_input_reference_select_test;
    import aisel_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] pos_input_sel;
    logic [3:0] neg_input_sel;
    logic diff_mode, gain_20x, temp_sensor_en, offset_cal;
    logic ref_supply_sel, ext_ref_connect, internal_ref_on, conv_sample, conv_done_pulse;
    int bad_count = 0;
    int check_count = 0;
    int last_len, done_count, hold_err, d0;
    logic [7:0] q;
    // forward pair table, reversed pairs swap the two columns
    logic [3:0] ptab [12] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6};
    logic [3:0] ntab [12] = '{4'h1, 4'h3, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h5, 4'h6, 4'h7};

    always #5 ref_clk = ~ref_clk;

    // only byte lane 0 carries register data
    aisel_top uut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .pos_input_sel(pos_input_sel),
        .neg_input_sel(neg_input_sel),
        .diff_mode(diff_mode),
        .gain_20x(gain_20x),
        .temp_sensor_en(temp_sensor_en),
        .offset_cal(offset_cal),
        .ref_supply_sel(ref_supply_sel),
        .ext_ref_connect(ext_ref_connect),
        .internal_ref_on(internal_ref_on),
        .conv_sample(conv_sample),
        .conv_done_pulse(conv_done_pulse)
    );

    aisel_analog_model core (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .routing({pos_input_sel, neg_input_sel, diff_mode, gain_20x, temp_sensor_en, offset_cal,
                  ref_supply_sel, ext_ref_connect, internal_ref_on}),
        .conv_sample(conv_sample),
        .conv_done_pulse(conv_done_pulse),
        .last_len(last_len),
        .done_count(done_count),
        .hold_err(hold_err)
    );

    // ****************
    // shared tasks
    // ****************
    task automatic end_of_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer, held until waitrequest is sampled low; bounded so a hang ends the run
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            bad_count++;
            end_of_test();
        end
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        while (conv_done_pulse !== 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 1000) begin
            bad_count++;
            end_of_test();
        end
        repeat (2) @(posedge ref_clk);
    endtask

    function automatic aisel_route_t exp_route(input logic [5:0] c);
        aisel_route_t r;
        logic [3:0] i;
        r = '0;
        r.neg = 4'h8;
        i = c[4:1] - 4'h4;
        if (c < 6'h08) begin
            r.pos = {1'b0, c[2:0]};
        end else if (c inside {6'h20, 6'h21, 6'h22}) begin
            r.pos = 4'h8 + {2'b00, c[1:0]};
            r.temp = (c == 6'h22);
        end else if (c > 6'h22 && c < 6'h28) begin
            r.cal = 1'b1;
            r.diff = 1'b1;
            r.gain20 = c[0];
            r.pos = (c < 6'h24) ? 4'h0 : ((c < 6'h26) ? 4'h3 : 4'h7);
            r.neg = r.pos;
        end else begin
            r.diff = 1'b1;
            r.gain20 = c[0];
            r.pos = c[5] ? ntab[i] : ptab[i];
            r.neg = c[5] ? ptab[i] : ntab[i];
        end
        return r;
    endfunction

    // gain only matters for differential routes, so it is masked elsewhere
    task automatic chk_route(input logic [5:0] c);
        chk({pos_input_sel, neg_input_sel, diff_mode, diff_mode & gain_20x, temp_sensor_en, offset_cal}, exp_route(c));
    endtask

    task automatic chk_ref(input logic [1:0] r);
        chk({ref_supply_sel, ext_ref_connect, internal_ref_on}, (r == 2'b01) ? 3'b010 : ((r == 2'b10) ? 3'b001 : 3'b100));
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (6) @(posedge ref_clk);
        chk_route(6'h00);
        chk_ref(2'b00);
        rst_n <= 1'b1;
        bus(1'b0, `AISEL_ADDR_SELECT, 8'h00);
        chk(q, 8'h00);
        bus(1'b1, `AISEL_ADDR_SELECT, 8'hFF);
        bus(1'b0, `AISEL_ADDR_SELECT, 8'h00);
        chk(q, 8'hFF);
        // a write without byte lane 0 must leave the register alone
        avs_byteenable <= 4'hE;
        bus(1'b1, `AISEL_ADDR_SELECT, 8'h12);
        avs_byteenable <= 4'hF;
        bus(1'b0, `AISEL_ADDR_SELECT, 8'h00);
        chk(q, 8'hFF);
        bus(1'b0, 6'h00, 8'h00);
        chk(q, 8'h00);
        // every channel code while idle
        for (d0 = 0; d0 < 64; d0++) begin
            bus(1'b1, `AISEL_ADDR_SELECT, {2'b00, d0[5:0]});
            repeat (2) @(posedge ref_clk);
            chk_route(d0[5:0]);
        end
        // every reference code, reserved one included
        for (d0 = 0; d0 < 4; d0++) begin
            bus(1'b1, `AISEL_ADDR_SELECT, {d0[1:0], 6'h01});
            bus(1'b0, `AISEL_ADDR_SELECT, 8'h00);
            chk(q, {d0[1:0], 6'h01});
            chk_ref(d0[1:0]);
        end
        // first conversion after enabling is long
        bus(1'b1, `AISEL_ADDR_SELECT, 8'h00);
        bus(1'b1, `AISEL_ADDR_CTRL, 8'hC0);
        wait_done();
        chk(last_len, 200);
        bus(1'b0, `AISEL_ADDR_CTRL, 8'h00);
        chk(q & 8'hD1, 8'h91);
        // selection written mid-conversion stays pending until completion
        bus(1'b1, `AISEL_ADDR_CTRL, 8'hD0);
        bus(1'b1, `AISEL_ADDR_SELECT, 8'h89);
        repeat (3) @(posedge ref_clk);
        chk_route(6'h00);
        chk_ref(2'b00);
        bus(1'b0, `AISEL_ADDR_ACTIVE, 8'h00);
        chk(q, 8'h00);
        wait_done();
        chk(last_len, 104);
        chk_route(6'h09);
        chk_ref(2'b10);
        // the reference changed, so the next one is long
        bus(1'b1, `AISEL_ADDR_CTRL, 8'hD0);
        wait_done();
        chk(last_len, 200);
        // converter kept enabled with the internal reference on while it settles
        chk({internal_ref_on, ext_ref_connect, ref_supply_sel}, 3'b100);
        bus(1'b0, `AISEL_ADDR_CTRL, 8'h00);
        chk(q & 8'h01, 8'h01);
        // abort by disabling, then re-enable to force a long conversion
        d0 = done_count;
        bus(1'b1, `AISEL_ADDR_CTRL, 8'hD0);
        repeat (20) @(posedge ref_clk);
        bus(1'b1, `AISEL_ADDR_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk(conv_sample, 1'b0);
        chk(done_count, d0);
        bus(1'b1, `AISEL_ADDR_CTRL, 8'hC0);
        wait_done();
        chk(last_len, 200);
        chk(hold_err, 0);
        end_of_test();
    end
endmodule
